// [spi_eeprom_front_end.sv]
// serial front end of a small spi eeprom
module spi_eeprom_front_end #(
	parameter int WRITE_CYCLE_CYCLES = spi_eeprom_pkg::WRITE_CYCLE_CYCLES
) (
	// system clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// serial link pins
	input  wire logic        serialClk,
	input  wire logic        chipPickN,
	input  wire logic        holdN,
	input  wire logic        serialIn,
	output logic             serialOut,
	output logic             serialOutEn,
	// memory core side
	input  wire logic [7:0]  readByte,
	output logic             writeStart,
	output logic [7:0]       writeCmd,
	output logic [15:0]      writeAddr,
	output logic [7:0]       writeData,
	// status
	output logic             writableFlag,
	output logic             busyFlag,
	output logic             standby
);

	localparam int CNT_W = $clog2(WRITE_CYCLE_CYCLES + 1);
	localparam logic [CNT_W-1:0] CYCLE_LOAD = CNT_W'(WRITE_CYCLE_CYCLES);
	localparam logic [CNT_W-1:0] CYCLE_LAST = CNT_W'(1);

	generate
		if (WRITE_CYCLE_CYCLES < 1) begin : g_bad_cycle
			$error("write cycle count must be at least one");
		end
	endgenerate

	// ----------------------------------------------------------------
	// state types
	// ----------------------------------------------------------------
	typedef struct packed {
		spi_eeprom_pkg::link_state_type state;
		logic [2:0]                     bitCnt;
		logic [7:0]                     rx;
		logic [7:0]                     cmd;
		logic [15:0]                    addr;
		logic                           addrIdx;
		logic [7:0]                     data;
		logic                           dataSeen;
		logic [7:0]                     tx;
		logic                           paused;
		logic                           frameTag;
	} link_type;

	typedef struct packed {
		logic                           powerUpHold;
		logic                           csPrev;
		logic                           seenTag;
		logic                           writable;
		logic                           busy;
		logic [CNT_W-1:0]               waitCnt;
		logic                           writeStart;
		logic [7:0]                     writeCmd;
		logic [15:0]                    writeAddr;
		logic [7:0]                     writeData;
		logic                           standby;
	} sys_type;

	typedef struct packed {
		logic                           data;
		logic                           en;
	} out_type;

	localparam link_type LINK_RESET = '{
		state:  spi_eeprom_pkg::LINK_INSTR,
		bitCnt: spi_eeprom_pkg::BIT_CNT_RESET,
		default: '0
	};
	localparam sys_type SYS_RESET = '{
		powerUpHold: spi_eeprom_pkg::POWER_UP_HOLD_RESET,
		writable:    spi_eeprom_pkg::WRITABLE_RESET,
		busy:        spi_eeprom_pkg::BUSY_RESET,
		default:     '0
	};
	localparam out_type OUT_RESET = '{default: '0};

	link_type link;
	link_type next_link;
	sys_type  sys;
	sys_type  next_sys;
	out_type  out;
	out_type  next_out;
	logic     fresh;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic spi_eeprom_pkg::link_state_type afterInstr(
		input logic [7:0] code
	);
		case (code)
			spi_eeprom_pkg::SET_WRITE_LATCH_CMD,
			spi_eeprom_pkg::CLEAR_WRITE_LATCH_CMD: afterInstr = spi_eeprom_pkg::LINK_DONE;
			spi_eeprom_pkg::STATUS_READ_CMD:       afterInstr = spi_eeprom_pkg::LINK_READ;
			spi_eeprom_pkg::STATUS_WRITE_CMD:      afterInstr = spi_eeprom_pkg::LINK_DATA;
			spi_eeprom_pkg::ARRAY_READ_CMD,
			spi_eeprom_pkg::ARRAY_WRITE_CMD,
			spi_eeprom_pkg::ID_PAGE_READ_CMD,
			spi_eeprom_pkg::ID_PAGE_PROGRAM_CMD:   afterInstr = spi_eeprom_pkg::LINK_ADDR;
			default:                               afterInstr = spi_eeprom_pkg::LINK_WAIT;
		endcase
	endfunction : afterInstr

	function automatic logic [7:0] statusByte(
		input logic busy,
		input logic writable
	);
		statusByte = 8'h00;
		statusByte[spi_eeprom_pkg::STATUS_BUSY_POS] = busy;
		statusByte[spi_eeprom_pkg::STATUS_WRITABLE_POS] = writable;
	endfunction : statusByte

	// ----------------------------------------------------------------
	// crossings
	// ----------------------------------------------------------------
	logic [1:0] pinSync;
	logic       csSync;
	logic       holdSync;
	logic [9:0] linkSync;
	logic       linkReset;
	logic       outReset;

	bit_sync #(
		.WIDTH    (2)
	) u_pin_sync (
		.clk      (clk_sys),
		.rst      (rst),
		.levelIn  ({chipPickN, holdN}),
		.levelOut (pinSync)
	);

	// read byte is taken as quasi-static while a frame runs
	bit_sync #(
		.WIDTH    (10)
	) u_link_sync (
		.clk      (serialClk),
		.rst      (sys.powerUpHold),
		.levelIn  ({readByte, sys.writable, sys.busy}),
		.levelOut (linkSync)
	);

	assign csSync    = pinSync[1];
	assign holdSync  = pinSync[0];
	assign linkReset = chipPickN | sys.powerUpHold;
	// output floats at once on deselect or on hold with the clock low
	assign outReset  = linkReset | (~holdN & ~serialClk);

	// ----------------------------------------------------------------
	// link side, rising serial clock
	// ----------------------------------------------------------------
	always_ff @(posedge serialClk or posedge linkReset) begin
		if (linkReset) begin
			fresh <= spi_eeprom_pkg::FRESH_RESET;
		end else begin
			fresh <= 1'b0;
		end
	end

	logic [2:0]                     bitNow;
	spi_eeprom_pkg::link_state_type stNow;
	logic [7:0]                     byteNow;
	logic                           byteDone;

	always_comb begin
		next_link = link;
		bitNow    = fresh ? spi_eeprom_pkg::BIT_CNT_RESET : link.bitCnt;
		stNow     = fresh ? spi_eeprom_pkg::LINK_INSTR : link.state;
		byteNow   = {link.rx[6:0], serialIn};
		byteDone  = (bitNow == 3'h7);
		if (!chipPickN) begin
			next_link.paused = ~holdN;
			if (fresh) begin
				next_link.frameTag = ~link.frameTag;
				next_link.state    = spi_eeprom_pkg::LINK_INSTR;
				next_link.bitCnt   = spi_eeprom_pkg::BIT_CNT_RESET;
				next_link.dataSeen = 1'b0;
				next_link.addrIdx  = 1'b0;
			end
			if (holdN) begin
				next_link.rx     = byteNow;
				next_link.bitCnt = bitNow + 3'h1;
				if (stNow == spi_eeprom_pkg::LINK_READ) begin
					next_link.tx = {link.tx[6:0], 1'b0};
				end
				case (stNow)
					spi_eeprom_pkg::LINK_INSTR: begin
						if (byteDone) begin
							next_link.cmd   = byteNow;
							next_link.state = afterInstr(byteNow);
							next_link.tx    = statusByte(linkSync[0], linkSync[1]);
						end
					end
					spi_eeprom_pkg::LINK_ADDR: begin
						if (byteDone) begin
							next_link.addr    = {link.addr[7:0], byteNow};
							next_link.addrIdx = ~link.addrIdx;
							if (link.addrIdx) begin
								next_link.tx = linkSync[9:2];
								if (link.cmd[0]) begin
									next_link.state = spi_eeprom_pkg::LINK_READ;
								end else begin
									next_link.state = spi_eeprom_pkg::LINK_DATA;
								end
							end
						end
					end
					spi_eeprom_pkg::LINK_DATA: begin
						if (byteDone) begin
							if (!link.dataSeen) begin
								next_link.data = byteNow;
							end
							next_link.dataSeen = 1'b1;
						end
					end
					spi_eeprom_pkg::LINK_READ: begin
						if (byteDone) begin
							if (link.cmd == spi_eeprom_pkg::STATUS_READ_CMD) begin
								next_link.tx = statusByte(linkSync[0], linkSync[1]);
							end else begin
								next_link.tx = linkSync[9:2];
							end
						end
					end
					spi_eeprom_pkg::LINK_DONE: begin
						next_link.state = spi_eeprom_pkg::LINK_WAIT;
					end
					default: begin
						next_link.state = spi_eeprom_pkg::LINK_WAIT;
					end
				endcase
			end
		end
	end

	always_ff @(posedge serialClk or posedge sys.powerUpHold) begin
		if (sys.powerUpHold) begin
			link <= LINK_RESET;
		end else begin
			link <= next_link;
		end
	end

	// ----------------------------------------------------------------
	// link side, falling serial clock
	// ----------------------------------------------------------------
	// in mode 1,1 a fall comes before the first rise, so state is stale
	always_comb begin
		next_out.en   = (link.state == spi_eeprom_pkg::LINK_READ)
			& ~link.paused & ~fresh;
		next_out.data = link.tx[7];
	end

	always_ff @(negedge serialClk or posedge outReset) begin
		if (outReset) begin
			out <= OUT_RESET;
		end else begin
			out <= next_out;
		end
	end

	// ----------------------------------------------------------------
	// system side
	// ----------------------------------------------------------------
	logic csRise;
	logic frameOk;

	// link fields are stable once the chip pick is seen high
	assign csRise  = csSync & ~sys.csPrev;
	assign frameOk = csRise & ~sys.powerUpHold & ~sys.busy & holdSync
		& ~link.paused & (link.frameTag != sys.seenTag)
		& (link.bitCnt == spi_eeprom_pkg::BIT_CNT_RESET);

	always_comb begin
		next_sys            = sys;
		next_sys.writeStart = 1'b0;
		next_sys.csPrev     = csSync;
		if (csSync) begin
			next_sys.powerUpHold = 1'b0;
		end
		if (sys.busy) begin
			if (sys.waitCnt == CYCLE_LAST) begin
				next_sys.busy     = 1'b0;
				next_sys.writable = 1'b0;
			end else begin
				next_sys.waitCnt = sys.waitCnt - CYCLE_LAST;
			end
		end
		if (csRise) begin
			next_sys.seenTag = link.frameTag;
		end
		if (frameOk) begin
			if (link.state == spi_eeprom_pkg::LINK_DONE) begin
				if (link.cmd == spi_eeprom_pkg::SET_WRITE_LATCH_CMD) begin
					next_sys.writable = 1'b1;
				end
				if (link.cmd == spi_eeprom_pkg::CLEAR_WRITE_LATCH_CMD) begin
					next_sys.writable = 1'b0;
				end
			end
			if (link.state == spi_eeprom_pkg::LINK_DATA && link.dataSeen
				&& sys.writable) begin
				next_sys.busy       = 1'b1;
				next_sys.waitCnt    = CYCLE_LOAD;
				next_sys.writeStart = 1'b1;
				next_sys.writeCmd   = link.cmd;
				next_sys.writeAddr  = link.addr;
				next_sys.writeData  = link.data;
			end
		end
		next_sys.standby = csSync & ~next_sys.busy;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sys <= SYS_RESET;
		end else begin
			sys <= next_sys;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign serialOut    = out.data;
	assign serialOutEn  = out.en;
	assign writeStart   = sys.writeStart;
	assign writeCmd     = sys.writeCmd;
	assign writeAddr    = sys.writeAddr;
	assign writeData    = sys.writeData;
	assign writableFlag = sys.writable;
	assign busyFlag     = sys.busy;
	assign standby      = sys.standby;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_set_frame;
		frameOk && link.state == spi_eeprom_pkg::LINK_DONE
			&& link.cmd == spi_eeprom_pkg::SET_WRITE_LATCH_CMD;
	endsequence

	sequence s_start;
		sys.writeStart && sys.busy && sys.waitCnt == CYCLE_LOAD;
	endsequence

	property p_set_latch;
		@(posedge clk_sys) disable iff (rst)
		s_set_frame |=> sys.writable;
	endproperty
	a_set_latch: assert property (p_set_latch)
		else $error("set latch frame did not set writable flag");

	property p_busy_on_start;
		@(posedge clk_sys) disable iff (rst)
		next_sys.writeStart |=> s_start ##1 sys.busy;
	endproperty
	a_busy_on_start: assert property (p_busy_on_start)
		else $error("busy flag not raised with full count on write start");

	property p_end_clears;
		@(posedge clk_sys) disable iff (rst)
		$fell(sys.busy) |-> !sys.writable && !sys.standby == $past(!csSync);
	endproperty
	a_end_clears: assert property (p_end_clears)
		else $error("write end left writable flag set");

	property p_start_needs_writable;
		@(posedge clk_sys) disable iff (rst)
		sys.writeStart |-> $past(sys.writable) && !$past(sys.busy);
	endproperty
	a_start_needs_writable: assert property (p_start_needs_writable)
		else $error("write started without writable flag");

	property p_start_aligned;
		@(posedge clk_sys) disable iff (rst)
		sys.writeStart |-> $past(link.bitCnt) == 3'h0 && $past(link.dataSeen)
			&& $past(link.state) == spi_eeprom_pkg::LINK_DATA;
	endproperty
	a_start_aligned: assert property (p_start_aligned)
		else $error("write started off a byte boundary or without data");

	property p_powerup_quiet;
		@(posedge clk_sys) disable iff (rst)
		sys.powerUpHold |=> !sys.writeStart && sys.writable == $past(sys.writable);
	endproperty
	a_powerup_quiet: assert property (p_powerup_quiet)
		else $error("command acted before first chip pick edge");

	property p_deselect_floats;
		@(posedge clk_sys) disable iff (rst)
		csSync |-> !serialOutEn;
	endproperty
	a_deselect_floats: assert property (p_deselect_floats)
		else $error("serial output driven while deselected");

	property p_wait_sticks;
		@(posedge serialClk) disable iff (linkReset)
		(link.state == spi_eeprom_pkg::LINK_WAIT && !fresh) |=>
			link.state == spi_eeprom_pkg::LINK_WAIT [*2];
	endproperty
	a_wait_sticks: assert property (p_wait_sticks)
		else $error("left wait state without deselect");

	property p_hold_freezes;
		@(posedge serialClk) disable iff (linkReset)
		(!holdN && !fresh) |=> $stable(link.bitCnt) && $stable(link.rx);
	endproperty
	a_hold_freezes: assert property (p_hold_freezes)
		else $error("bit position moved during hold");

	property p_bit_advance;
		@(posedge serialClk) disable iff (linkReset)
		(holdN && !fresh) |=> link.bitCnt == $past(link.bitCnt) + 3'h1
			&& link.rx[0] == $past(serialIn);
	endproperty
	a_bit_advance: assert property (p_bit_advance)
		else $error("input bit not taken on rising edge");

	property p_fresh_restart;
		@(posedge serialClk) disable iff (linkReset)
		(fresh && holdN) |=> link.bitCnt == 3'h1
			&& link.state == spi_eeprom_pkg::LINK_INSTR;
	endproperty
	a_fresh_restart: assert property (p_fresh_restart)
		else $error("new selection did not restart the instruction byte");

endmodule : spi_eeprom_front_end

// [spi_eeprom_pkg.sv]
// constants and types shared by the serial eeprom front end
// Operation
// - read data leaves on falling serial clock edges, MSB first
// - serial output stays high impedance unless read data is returned
// - input bits are sampled on rising serial clock edges, MSB first
// - chip pick high deselects and releases the output at once
// - standby only when deselected and no write cycle runs
// - hold starts only with hold low while the serial clock is low
// - in hold the output floats and clock and input are ignored
// - hold ends with hold high while or once the clock is low
// - deselect during hold abandons the paused command
// - after power-up a chip pick falling edge is needed before selection
// - program commands execute only with the writable flag already set
// - program commands need a clean frame of whole bytes
// - program commands need at least one complete data byte
// - the write starts only on a byte-aligned chip pick rise
// - a chip pick rise off a byte boundary discards the program command
// - reads need a clean frame and whole instruction and address bytes
// - read data streams until the chip pick rises, without limit
// - every command opens with an 8-bit instruction, MSB first
// - an unknown instruction parks the device until deselect
// - writable flag set by set latch, cleared by clear, write end, power-up
// - busy flag is one throughout a write cycle, zero when ready
package spi_eeprom_pkg;

	// ----------------------------------------------------------------
	// instruction encodings
	// ----------------------------------------------------------------
	localparam logic [7:0] SET_WRITE_LATCH_CMD   = 8'h06;
	localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
	localparam logic [7:0] STATUS_READ_CMD       = 8'h05;
	localparam logic [7:0] STATUS_WRITE_CMD      = 8'h01;
	localparam logic [7:0] ARRAY_READ_CMD        = 8'h03;
	localparam logic [7:0] ARRAY_WRITE_CMD       = 8'h02;
	localparam logic [7:0] ID_PAGE_READ_CMD      = 8'h83;
	localparam logic [7:0] ID_PAGE_PROGRAM_CMD   = 8'h82;
	// lock commands share codes, the address tells them apart
	localparam logic [7:0] LOCK_STATE_READ_CMD   = ID_PAGE_READ_CMD;
	localparam logic [7:0] ID_PAGE_LOCK_CMD      = ID_PAGE_PROGRAM_CMD;

	// ----------------------------------------------------------------
	// status byte layout and reset values
	// ----------------------------------------------------------------
	localparam int         STATUS_BUSY_POS      = 0;
	localparam int         STATUS_WRITABLE_POS  = 1;
	localparam logic       POWER_UP_HOLD_RESET  = 1'b1;
	localparam logic       WRITABLE_RESET       = 1'b0;
	localparam logic       BUSY_RESET           = 1'b0;
	localparam logic       FRESH_RESET          = 1'b1;
	localparam logic [2:0] BIT_CNT_RESET        = 3'h0;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int WRITE_CYCLE_NS     = 4000000;
	localparam int CLK_SYS_PERIOD_NS  = 40;
	// longest time, so round down
	localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_NS / CLK_SYS_PERIOD_NS;

	// ----------------------------------------------------------------
	// link states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		LINK_INSTR = 3'h0,
		LINK_ADDR  = 3'h1,
		LINK_DATA  = 3'h3,
		LINK_READ  = 3'h2,
		LINK_DONE  = 3'h6,
		LINK_WAIT  = 3'h7
	} link_state_type;

endpackage : spi_eeprom_pkg

// [bit_sync.sv]
// two flip-flop level synchroniser
module bit_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// levels
	input  wire logic [WIDTH-1:0] levelIn,
	output logic      [WIDTH-1:0] levelOut
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_type;

	sync_type s;
	sync_type next_s;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("bit_sync width must be at least one");
		end
	endgenerate

	always_comb begin
		next_s.stage1 = levelIn;
		next_s.stage2 = s.stage1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign levelOut = s.stage2;

endmodule : bit_sync

// [spi_master_model.sv]
// master side model of the serial link, clock modes 0,0 and 1,1
module spi_master_model #(
	parameter int HALF_NS = 32
) (
	// link pins toward the device
	output logic      serialClk,
	output logic      chipPickN,
	output logic      holdN,
	output logic      serialIn,
	// device output value and its enable
	input  wire logic serialOut,
	input  wire logic serialOutEn
);
	timeunit 1ns;
	timeprecision 1ps;

	logic idleHigh;
	logic lineQ;

	initial begin
		serialClk = 1'b0;
		chipPickN = 1'b1;
		holdN     = 1'b1;
		serialIn  = 1'b0;
		idleHigh  = 1'b0;
		lineQ     = 1'b0;
	end

	// ----------------------------------------------------------------
	// frame start, with optional stray edges while deselected
	// ----------------------------------------------------------------
	task automatic select(input logic hi, input int noise);
		idleHigh = hi;
		repeat (noise) begin
			serialIn  = ~serialIn;
			serialClk = ~serialClk;
			#HALF_NS;
		end
		serialClk = hi;
		#HALF_NS;
		chipPickN = 1'b0;
		#HALF_NS;
	endtask : select

	// ----------------------------------------------------------------
	// bit transfer: data set after the fall, taken at the rise
	// ----------------------------------------------------------------
	task automatic bits(input logic [39:0] v, input int n,
		output logic [39:0] r);
		r = '0;
		for (int i = n - 1; i >= 0; i--) begin
			serialClk = 1'b0;
			serialIn  = v[i];
			#HALF_NS;
			// a floating line shows the inverse of its last level
			lineQ     = serialOutEn ? serialOut : ~lineQ;
			r[i]      = lineQ;
			serialClk = 1'b1;
			#HALF_NS;
		end
	endtask : bits

	// hold is only lowered with the clock low
	task automatic pause(input int n, input logic resume);
		serialClk = 1'b0;
		#HALF_NS;
		holdN = 1'b0;
		#HALF_NS;
		repeat (n) begin
			serialIn  = ~serialIn;
			serialClk = 1'b1;
			#HALF_NS;
			serialClk = 1'b0;
			#HALF_NS;
		end
		if (resume) begin
			holdN = 1'b1;
			#HALF_NS;
		end
	endtask : pause

	// cs rises with the clock at idle, then data line is let go
	task automatic deselect();
		serialClk = idleHigh;
		#HALF_NS;
		chipPickN = 1'b1;
		#HALF_NS;
		holdN    = 1'b1;
		serialIn = ~serialIn;
		#(3 * HALF_NS);
	endtask : deselect

endmodule : spi_master_model

// [test_spi_eeprom_serial_front_end.sv]
// self-checking bench of the serial eeprom front end
module test_spi_eeprom_serial_front_end;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int CYCLES = 20;
	localparam int LIMIT  = 6000;

	logic        clk_sys;
	logic        rst;
	logic [7:0]  readByte;
	logic        serialClk;
	logic        chipPickN;
	logic        holdN;
	logic        serialIn;
	logic        serialOut;
	logic        serialOutEn;
	logic        writeStart;
	logic [7:0]  writeCmd;
	logic [15:0] writeAddr;
	logic [7:0]  writeData;
	logic        writableFlag;
	logic        busyFlag;
	logic        standby;
	int          nFail;
	int          checkCount;
	int          cycleCount;
	int          starts;
	int          busyLen;
	int          enCount;
	int          s;
	int          e;
	logic [39:0] r;

	spi_eeprom_front_end #(
		.WRITE_CYCLE_CYCLES(CYCLES)
	) u_spi_eeprom_front_end (
		.clk_sys(clk_sys), .rst(rst), .serialClk(serialClk),
		.chipPickN(chipPickN), .holdN(holdN), .serialIn(serialIn),
		.serialOut(serialOut), .serialOutEn(serialOutEn),
		.readByte(readByte), .writeStart(writeStart),
		.writeCmd(writeCmd), .writeAddr(writeAddr),
		.writeData(writeData), .writableFlag(writableFlag),
		.busyFlag(busyFlag), .standby(standby)
	);

	spi_master_model u_spi_master_model (
		.serialClk(serialClk), .chipPickN(chipPickN), .holdN(holdN),
		.serialIn(serialIn), .serialOut(serialOut),
		.serialOutEn(serialOutEn)
	);

	initial clk_sys = 1'b0;
	always #20 clk_sys = ~clk_sys;

	// ----------------------------------------------------------------
	// monitors and the hang limit
	// ----------------------------------------------------------------
	always @(posedge serialOutEn) enCount = enCount + 1;

	always @(posedge clk_sys) begin
		cycleCount <= cycleCount + 1;
		if (writeStart === 1'b1) starts <= starts + 1;
		if (busyFlag === 1'b1) busyLen <= busyLen + 1;
		if (cycleCount == LIMIT) begin
			nFail = nFail + 1;
			report_and_stop();
		end
	end

	// ----------------------------------------------------------------
	// compares and frame helpers
	// ----------------------------------------------------------------
	task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
		checkCount++;
		if (got !== exp) begin
			nFail++;
			$display("unexpected at %0t: byte %h not %h", $time, got, exp);
		end
	endtask : checkByte

	task automatic checkPort(input logic [15:0] got, input logic [15:0] exp);
		checkCount++;
		if (got !== exp) begin
			nFail++;
			$display("unexpected at %0t: port %h not %h", $time, got, exp);
		end
	endtask : checkPort

	task automatic waitCycles(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : waitCycles

	task automatic frame(input logic hi, input logic [39:0] v, input int n);
		logic [39:0] q;
		u_spi_master_model.select(hi, 0);
		u_spi_master_model.bits(v, n, q);
		u_spi_master_model.deselect();
		waitCycles(8);
	endtask : frame

	// stray clocks before select must not disturb the read
	task automatic status(input logic hi, input logic [7:0] exp);
		logic [39:0] q;
		checkPort(16'(serialOutEn), 16'h0000);
		u_spi_master_model.select(hi, 4);
		u_spi_master_model.bits(40'h05_0000, 24, q);
		checkByte(q[15:8], exp);
		checkByte(q[7:0], exp);
		u_spi_master_model.deselect();
		checkPort(16'(serialOutEn), 16'h0000);
		waitCycles(8);
	endtask : status

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", checkCount, nFail);
		if (nFail == 0 && checkCount > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		readByte = 8'h00;
		{nFail, checkCount, cycleCount, starts, busyLen, enCount} = '0;
		// chip pick falls during power-up, never qualified
		u_spi_master_model.select(1'b0, 0);
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		readByte <= 8'ha5;
		waitCycles(4);
		checkPort(16'(writableFlag), 16'h0000);
		checkPort(16'(busyFlag), 16'h0000);
		e = enCount;
		u_spi_master_model.bits(40'h05_0000, 24, r);
		checkPort(16'(enCount), 16'(e));
		u_spi_master_model.deselect();
		waitCycles(8);
		checkPort(16'(standby), 16'h0001);
		status(1'b0, 8'h00);
		s = starts;
		frame(1'b0, 40'h02_0010_5a, 32);
		checkPort(16'(starts), 16'(s));
		frame(1'b1, 40'h06, 8);
		checkPort(16'(writableFlag), 16'h0001);
		status(1'b1, 8'h02);
		frame(1'b0, 40'h02_0010, 24);
		checkPort(16'(starts), 16'(s));
		frame(1'b0, {5'h00, 8'h02, 16'h0010, 8'h5a, 3'h5}, 35);
		checkPort(16'(starts), 16'(s));
		e = enCount;
		frame(1'b0, 40'hff_ffff, 24);
		checkPort(16'(enCount), 16'(e));
		status(1'b0, 8'h02);
		// aligned write, paused in hold mid data byte
		u_spi_master_model.select(1'b0, 0);
		u_spi_master_model.bits(40'h02_1234_5, 28, r);
		u_spi_master_model.pause(3, 1'b1);
		u_spi_master_model.bits(40'hc, 4, r);
		u_spi_master_model.bits(40'h77, 8, r);
		u_spi_master_model.deselect();
		waitCycles(5);
		checkPort(16'(standby), 16'h0000);
		waitCycles(30);
		checkPort(16'(starts), 16'(s + 1));
		checkPort(16'(writeCmd), 16'(spi_eeprom_pkg::ARRAY_WRITE_CMD));
		checkPort(writeAddr, 16'h1234);
		checkPort(16'(writeData), 16'h005c);
		checkPort(16'(busyLen), 16'(CYCLES));
		checkPort(16'(writableFlag), 16'h0000);
		checkPort(16'(standby), 16'h0001);
		// hold during a read drops the output
		e = enCount;
		u_spi_master_model.select(1'b0, 0);
		u_spi_master_model.bits(40'h05, 8, r);
		u_spi_master_model.pause(3, 1'b0);
		checkPort(16'(serialOutEn), 16'h0000);
		checkPort(16'(enCount), 16'(e + 1));
		u_spi_master_model.deselect();
		waitCycles(8);
		// deselect while paused abandons a complete write
		frame(1'b0, 40'h06, 8);
		s = starts;
		u_spi_master_model.select(1'b0, 0);
		u_spi_master_model.bits(40'h02_0010_5a, 32, r);
		u_spi_master_model.pause(2, 1'b0);
		u_spi_master_model.deselect();
		waitCycles(10);
		checkPort(16'(starts), 16'(s));
		checkPort(16'(writableFlag), 16'h0001);
		frame(1'b0, 40'h04, 8);
		checkPort(16'(writableFlag), 16'h0000);
		// status write carries only a data byte after the instruction
		frame(1'b0, 40'h06, 8);
		frame(1'b0, 40'h01_3c, 16);
		waitCycles(30);
		checkPort(16'(starts), 16'(s + 1));
		checkPort(16'(writeCmd), 16'(spi_eeprom_pkg::STATUS_WRITE_CMD));
		checkPort(16'(writeData), 16'h003c);
		// a read leaves stale state for the next mode 1,1 frame
		status(1'b1, 8'h00);
		// array read streams the same byte on and on
		e = enCount;
		u_spi_master_model.select(1'b1, 0);
		u_spi_master_model.bits(40'h03_0020, 24, r);
		checkPort(16'(enCount), 16'(e));
		u_spi_master_model.bits(40'h0, 24, r);
		checkByte(r[23:16], 8'ha5);
		checkByte(r[15:8], 8'ha5);
		checkByte(r[7:0], 8'ha5);
		u_spi_master_model.deselect();
		report_and_stop();
	end

endmodule : test_spi_eeprom_serial_front_end
